// ### rtl/vcr_resource_regs.v
// Channel resource capability, control and status register bank
`include "vcr_defines.vh"

module vcr_resource_regs (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [11:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire [3:0]  reg_be,
    output reg  [31:0] reg_rdata_q,
    input  wire        vc0_negotiating,
    input  wire [7:0]  tc_req,
    input  wire        vc0_req,
    input  wire        vc1_req,
    output reg         vc1_enable_q,
    output reg  [2:0]  vc1_id_q,
    output reg  [6:0]  vc0_class_map_q,
    output reg  [6:0]  vc1_class_map_q,
    output reg  [2:0]  vc1_port_arb_select_q,
    output reg  [7:0]  tc_to_vc1_q,
    output reg         grant_vc0_q,
    output reg         grant_vc1_q
);

// ==========================================
// Address decode; full compare so aliases read zero
wire        hit_vc0_ctl = (reg_addr == `VCR_OFF_VC0_CTL);
wire        hit_vc1_ctl = (reg_addr == `VCR_OFF_VC1_CTL);
wire        wr_vc0_ctl  = reg_wr & hit_vc0_ctl;
wire        wr_vc1_ctl  = reg_wr & hit_vc1_ctl;
wire        vc1_active  = vc1_req & vc1_enable_q;

// ==========================================
// Register state and next values
reg  [2:0]  vc0_port_arb_select_q;
reg  [2:0]  vc0_port_arb_select_d;
reg  [6:0]  vc0_class_map_d;
reg         vc1_enable_d;
reg  [2:0]  vc1_id_d;
reg  [2:0]  vc1_port_arb_select_d;
reg  [6:0]  vc1_class_map_d;
reg         vc0_np_q;
reg         vc0_np_d;
reg         grant_vc0_d;
reg         grant_vc1_d;
reg  [31:0] reg_rdata_d;
reg  [31:0] rd_word;
reg  [31:0] vc0_ctl;
reg  [31:0] vc1_ctl;
wire [7:0]  tc_to_vc1_d;

// ==========================================
// Fixed words
wire [31:0] vc0_cap_word = `VCR_VC0_CAP_VAL;
wire [31:0] vc1_cap_word = `VCR_VC1_CAP_VAL;
// Status sits in the upper half of the word at 018h
wire [31:0] vc0_sts_word = {14'h0000, vc0_np_q, 17'h0_0000};

// ==========================================
// Channel 0 control: select and map only
always @* begin
    vc0_port_arb_select_d = vc0_port_arb_select_q;
    vc0_class_map_d       = vc0_class_map_q;
    // Enable and identifier are fixed here
    if (wr_vc0_ctl) begin
        // Stored only; no table exists behind it
        if (reg_be[2]) begin
            vc0_port_arb_select_d = reg_wdata[`VCR_PAS_HI:`VCR_PAS_LO];
        end
        if (reg_be[0]) begin
            vc0_class_map_d = reg_wdata[`VCR_MAP_HI:`VCR_MAP_LO];
        end
    end
end

// ==========================================
// Channel 1 control: enable, identifier, select and map
always @* begin
    vc1_enable_d          = vc1_enable_q;
    vc1_id_d              = vc1_id_q;
    vc1_port_arb_select_d = vc1_port_arb_select_q;
    vc1_class_map_d       = vc1_class_map_q;
    if (wr_vc1_ctl) begin
        // Enable and identifier share byte lane 3
        if (reg_be[3]) begin
            vc1_enable_d = reg_wdata[`VCR_EN_BIT];
            vc1_id_d     = reg_wdata[`VCR_ID_HI:`VCR_ID_LO];
        end
        // Other values are software's fault, held as written
        if (reg_be[2]) begin
            vc1_port_arb_select_d = reg_wdata[`VCR_PAS_HI:`VCR_PAS_LO];
        end
        if (reg_be[0]) begin
            vc1_class_map_d = reg_wdata[`VCR_MAP_HI:`VCR_MAP_LO];
        end
    end
end

// ==========================================
// Negotiation status follows the link, one cycle late
always @* begin
    vc0_np_d = vc0_negotiating;
end

// ==========================================
// Control and status flip-flops
always @(posedge core_clk) begin
    if (sys_rst) begin
        vc0_port_arb_select_q <= `VCR_PAS_RST;
        vc0_class_map_q       <= `VCR_VC0_MAP_RST;
        vc1_enable_q          <= `VCR_VC1_EN_RST;
        vc1_id_q              <= `VCR_VC1_ID_RST;
        vc1_port_arb_select_q <= `VCR_PAS_RST;
        vc1_class_map_q       <= `VCR_VC1_MAP_RST;
        vc0_np_q              <= `VCR_NP_RST;
    end else begin
        vc0_port_arb_select_q <= vc0_port_arb_select_d;
        vc0_class_map_q       <= vc0_class_map_d;
        vc1_enable_q          <= vc1_enable_d;
        vc1_id_q              <= vc1_id_d;
        vc1_port_arb_select_q <= vc1_port_arb_select_d;
        vc1_class_map_q       <= vc1_class_map_d;
        vc0_np_q              <= vc0_np_d;
    end
end

// ==========================================
// Control words as software sees them
always @* begin
    vc0_ctl = 32'h0000_0000;
    vc0_ctl[`VCR_EN_BIT] = 1'b1;
    vc0_ctl[`VCR_ID_HI:`VCR_ID_LO] = `VCR_VC0_ID;
    vc0_ctl[`VCR_PAS_HI:`VCR_PAS_LO] = vc0_port_arb_select_q;
    vc0_ctl[`VCR_MAP_HI:`VCR_MAP_LO] = vc0_class_map_q;
end

always @* begin
    // Bits 30 to 27 and the other reserved spans stay zero
    vc1_ctl = 32'h0000_0000;
    vc1_ctl[`VCR_EN_BIT] = vc1_enable_q;
    vc1_ctl[`VCR_ID_HI:`VCR_ID_LO] = vc1_id_q;
    vc1_ctl[`VCR_PAS_HI:`VCR_PAS_LO] = vc1_port_arb_select_q;
    vc1_ctl[`VCR_MAP_HI:`VCR_MAP_LO] = vc1_class_map_q;
end

// ==========================================
// Read path
always @* begin
    // Unmapped words read zero; writes there are dropped
    case (reg_addr)
        `VCR_OFF_VC0_CAP: rd_word = vc0_cap_word;
        `VCR_OFF_VC0_CTL: rd_word = vc0_ctl;
        `VCR_OFF_VC0_STS: rd_word = vc0_sts_word;
        `VCR_OFF_VC1_CAP: rd_word = vc1_cap_word;
        `VCR_OFF_VC1_CTL: rd_word = vc1_ctl;
        default:          rd_word = 32'h0000_0000;
    endcase
end

always @* begin
    if (reg_rd) begin
        reg_rdata_d = rd_word;
    end else begin
        // Idle cycles return zero so stale data never lingers
        reg_rdata_d = 32'h0000_0000;
    end
end

// ==========================================
// Class steering: one bit per traffic class
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : g_tc
        if (g == 0) begin : g_none
            // Class 0 always stays on channel 0
            assign tc_to_vc1_d[g] = 1'b0;
        end else begin : g_map
            assign tc_to_vc1_d[g] = tc_req[g] & vc1_enable_q & vc1_class_map_q[g-1];
        end
    end
endgenerate

// ==========================================
// Fixed priority: channel 1 wins whenever it is enabled and requesting
always @* begin
    // A disabled channel 1 must not block channel 0
    grant_vc1_d = vc1_active;
    grant_vc0_d = vc0_req & ~vc1_active;
end

// ==========================================
// Output flip-flops
always @(posedge core_clk) begin
    // Every output leaves straight from a flip-flop
    if (sys_rst) begin
        reg_rdata_q <= 32'h0000_0000;
        tc_to_vc1_q <= 8'h00;
        grant_vc0_q <= 1'b0;
        grant_vc1_q <= 1'b0;
    end else begin
        reg_rdata_q <= reg_rdata_d;
        tc_to_vc1_q <= tc_to_vc1_d;
        grant_vc0_q <= grant_vc0_d;
        grant_vc1_q <= grant_vc1_d;
    end
end

endmodule

// ### rtl/vcr_defines.vh
// Offsets, field positions, reset values and encodings of the channel resource bank
`ifndef VCR_DEFINES_VH
`define VCR_DEFINES_VH

`define VCR_ADDR_W          12
`define VCR_OFF_VC0_CAP     12'h010
`define VCR_OFF_VC0_CTL     12'h014
`define VCR_OFF_VC0_STS     12'h018
`define VCR_OFF_VC1_CAP     12'h01C
`define VCR_OFF_VC1_CTL     12'h020

`define VCR_VC0_CAP_VAL     32'h0000_0001
`define VCR_VC1_CAP_VAL     32'h0000_8001
`define VCR_VC0_CTL_RST     32'h8000_00FE
`define VCR_VC1_CTL_RST     32'h0100_0000
`define VCR_VC0_STS_RST     16'h0002

`define VCR_EN_BIT          31
`define VCR_ID_HI           26
`define VCR_ID_LO           24
`define VCR_PAS_HI          19
`define VCR_PAS_LO          17
`define VCR_MAP_HI          7
`define VCR_MAP_LO          1
`define VCR_NP_BIT          1

`define VCR_VC0_ID          3'h0
`define VCR_VC1_ID_RST      3'h1
`define VCR_VC0_MAP_RST     7'h7F
`define VCR_VC1_MAP_RST     7'h00
`define VCR_VC1_PAS_TWRR    3'h4
`define VCR_PAS_RST         3'h0
`define VCR_VC1_EN_RST      1'b0
`define VCR_NP_RST          1'b1

`endif

// ### verif/vcr_regs_asserts.sv
// Checker for the channel resource register bank
module vcr_regs_chk (
    input wire logic        core_clk, sys_rst, reg_wr, reg_rd, vc0_req, vc1_req,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata, reg_rdata_q,
    input wire logic [3:0]  reg_be,
    input wire logic        vc1_enable_q, grant_vc0_q, grant_vc1_q,
    input wire logic [6:0]  vc1_class_map_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence rd_at(logic [11:0] a); reg_rd && reg_addr == a; endsequence
    sequence wr_vc1; reg_wr && reg_addr == 12'h020; endsequence
    cap0_value_a: assert property (rd_at(12'h010) |=> reg_rdata_q == 32'h0000_0001) else $error("cap0 bad");
    cap1_value_a: assert property (rd_at(12'h01C) |=> reg_rdata_q == 32'h0000_8001) else $error("cap1 bad");
    ctl0_fixed_a: assert property (rd_at(12'h014) |=> reg_rdata_q[31:24] == 8'h80) else $error("ctl0 bad");
    ctl1_resv_a: assert property (rd_at(12'h020) |=> reg_rdata_q[30:27] == 4'h0) else $error("ctl1 bad");
    vc1_enable_a: assert property (wr_vc1 ##0 reg_be[3] |=> vc1_enable_q == $past(reg_wdata[31])) else $error("en");
    vc1_map_a: assert property (wr_vc1 ##0 reg_be[0] |=> vc1_class_map_q == $past(reg_wdata[7:1])) else $error("map");
    vc1_grant_a: assert property (vc1_req && vc1_enable_q |=> grant_vc1_q) else $error("vc1 not granted");
    vc0_yield_a: assert property (grant_vc1_q |-> !grant_vc0_q) else $error("both granted");
    vc0_grant_a: assert property (vc0_req && !(vc1_req && vc1_enable_q) |=> grant_vc0_q) else $error("vc0 lost");
endmodule
bind vcr_resource_regs vcr_regs_chk u_chk (.core_clk, .sys_rst, .reg_wr, .reg_rd, .vc0_req, .vc1_req, .reg_addr,
    .reg_wdata, .reg_rdata_q, .reg_be, .vc1_enable_q, .grant_vc0_q, .grant_vc1_q, .vc1_class_map_q);

// ### verif/vcr_hub_model.sv
// Far-end hub model: negotiation window and channel requests
module vcr_hub_model #(parameter int NEG = 40) (
    input  wire logic  core_clk,
    input  wire logic  sys_rst,
    output logic       vc0_negotiating,
    output logic [7:0] tc_req,
    output logic       vc0_req,
    output logic       vc1_req
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // Negotiation ends a fixed time after reset
    always @(posedge core_clk) begin
        cnt <= sys_rst ? 0 : (cnt < NEG ? cnt + 1 : cnt);
        vc0_negotiating <= sys_rst || cnt < NEG;
        {tc_req, vc0_req, vc1_req} <= sys_rst ? 10'h0 : 10'($urandom);
    end
endmodule

// ### verif/tb.sv
// Self-checking bench for the channel resource register bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, vc0_negotiating, vc0_req, vc1_req, pe = 1;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata_q, c0 = 32'h8000_00FE, c1 = 32'h0100_0000, m, d;
    logic [3:0]  reg_be = 0;
    logic [7:0]  tc_req, tc_to_vc1_q;
    logic [6:0]  vc0_class_map_q, vc1_class_map_q;
    logic [2:0]  vc1_id_q, vc1_port_arb_select_q;
    logic        vc1_enable_q, grant_vc0_q, grant_vc1_q;
    int n_mismatch = 0, checked = 0, cyc = 0, i;
    logic [11:0] addrs [6] = '{12'h010, 12'h014, 12'h018, 12'h01C, 12'h020, 12'h024};
    initial forever #5 core_clk = ~core_clk;
    vcr_resource_regs DUT (
        .core_clk              (core_clk),
        .sys_rst               (sys_rst),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_be                (reg_be),
        .reg_rdata_q           (reg_rdata_q),
        .vc0_negotiating       (vc0_negotiating),
        .tc_req                (tc_req),
        .vc0_req               (vc0_req),
        .vc1_req               (vc1_req),
        .vc1_enable_q          (vc1_enable_q),
        .vc1_id_q              (vc1_id_q),
        .vc0_class_map_q       (vc0_class_map_q),
        .vc1_class_map_q       (vc1_class_map_q),
        .vc1_port_arb_select_q (vc1_port_arb_select_q),
        .tc_to_vc1_q           (tc_to_vc1_q),
        .grant_vc0_q           (grant_vc0_q),
        .grant_vc1_q           (grant_vc1_q)
    );
    vcr_hub_model u_hub (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .vc0_negotiating (vc0_negotiating),
        .tc_req          (tc_req),
        .vc0_req         (vc0_req),
        .vc1_req         (vc1_req)
    );
    task end_sim;
        if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // A hang ends the run as a failure
    always @(posedge core_clk) if (++cyc == 1000) begin
        n_mismatch++;
        end_sim;
    end
    // ==========================================
    // Steering and grants, against the hub's previous cycle
    logic [7:0]  p_tc = 0;
    logic        p_rst = 1, p_r0 = 0, p_r1 = 0;
    logic [31:0] p_c1 = 32'h0100_0000, e_l;
    function logic [31:0] ex_link(input logic [7:0] tc, input logic r0, r1, input logic [31:0] c);
        return {22'h0, r1 & c[31], r0 & ~(r1 & c[31]), tc[7:1] & c[7:1] & {7{c[31]}}, 1'b0};
    endfunction
    always @(negedge core_clk) begin
        e_l = p_rst ? 32'h0 : ex_link(p_tc, p_r0, p_r1, p_c1);
        chk({22'h0, grant_vc1_q, grant_vc0_q, tc_to_vc1_q}, e_l);
        {p_tc, p_r0, p_r1, p_rst, p_c1} = {tc_req, vc0_req, vc1_req, sys_rst, c1};
    end
    task chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [31:0] ex(input logic [11:0] a);
        case (a)
            12'h010: return 32'h0000_0001;
            12'h014: return c0;
            12'h018: return {14'h0, pe, 17'h0};
            12'h01C: return 32'h0000_8001;
            12'h020: return c1;
            default: return 32'h0;
        endcase
    endfunction
    task rd(input logic [11:0] a);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 0;
        #1 chk(reg_rdata_q, ex(a));
    endtask
    task wr(input logic [11:0] a, input logic [31:0] w, input logic [3:0] b);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata, reg_be} <= {1'b1, a, w, b};
        @(posedge core_clk);
        reg_wr <= 0;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        if (a == 12'h014) c0 = c0 & ~(m & 32'h000E_00FE) | w & m & 32'h000E_00FE;
        if (a == 12'h020) c1 = c1 & ~(m & 32'h870E_00FE) | w & m & 32'h870E_00FE;
        #1 chk({vc1_enable_q, vc1_id_q, vc1_port_arb_select_q, vc1_class_map_q, vc0_class_map_q},
               {c1[31], c1[26:24], c1[19:17], c1[7:1], c0[7:1]});
    endtask
    initial begin
        void'($urandom(45));
        repeat (3) @(posedge core_clk);
        sys_rst <= 0;
        foreach (addrs[k]) rd(addrs[k]);
        wr(12'h014, 32'hFFFF_FFFF, 4'hF);
        wr(12'h020, 32'hFFF9_FFFF, 4'hF);
        rd(12'h014);
        rd(12'h020);
        repeat (40) @(posedge core_clk);
        pe = 0;
        repeat (60) begin
            d = $urandom;
            i = $urandom_range(5);
            if (i == 4) d[19:17] = 3'h4;
            wr(addrs[i], d, 4'($urandom));
            rd(addrs[$urandom_range(5)]);
        end
        end_sim;
    end
endmodule
